/* File: hdl/vts_angle_hist.sv */
// Angle history for one channel: shift register of tick-sampled angles.
// Assumes tick_i is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module vts_angle_hist #(
  parameter int DEPTH = 8
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        tick_i,
  input  wire logic [11:0] angle_i,
  output logic      [11:0] old_angle_o,
  output logic      [11:0] diff_o
);
  import vts_pkg::*;
  logic [11:0] hist_reg [DEPTH];
  logic [11:0] raw_diff;
  // Wrapped magnitude of the angle change, 0..180 deg
  assign raw_diff    = (angle_i >= hist_reg[DEPTH-1]) ? angle_i - hist_reg[DEPTH-1]
                                                      : hist_reg[DEPTH-1] - angle_i;
  assign diff_o      = (raw_diff > (ANGLE_FULL >> 1)) ? ANGLE_FULL - raw_diff : raw_diff;
  assign old_angle_o = hist_reg[DEPTH-1];
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) hist_reg[i] <= 12'h000;
    end else if (tick_i) begin
      hist_reg[0] <= angle_i;
      for (int i = 1; i < DEPTH; i++) hist_reg[i] <= hist_reg[i-1];
    end
  end
endmodule : vts_angle_hist

/* File: hdl/vts_pkg.sv */
// Package: constants for voltage transformer supervision.
// Assumes magnitudes in hundredths of nominal voltage, angles in tenths of a degree.
package vts_pkg;
  // ------------------------------------------------------------
  // Settings (hundredths of nominal, tenths of degree)
  // ------------------------------------------------------------
  localparam logic [6:0]  LOW_PICKUP_MIN   = 7'h05;
  localparam logic [6:0]  LOW_PICKUP_MAX   = 7'h32;
  localparam logic [6:0]  LOW_PICKUP_RST   = 7'h05;
  localparam logic [6:0]  HIGH_DETECT_MIN  = 7'h01;
  localparam logic [6:0]  HIGH_DETECT_MAX  = 7'h6E;
  localparam logic [6:0]  HIGH_DETECT_RST  = 7'h50;
  localparam logic [9:0]  ANGLE_LIM_MIN    = 10'h014;
  localparam logic [9:0]  ANGLE_LIM_MAX    = 10'h384;
  localparam logic [9:0]  ANGLE_LIM_RST    = 10'h032;
  localparam logic [11:0] ANGLE_FULL       = 12'h0E10;
  localparam logic        FUSE_CHECK_RST   = 1'b1;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int TICK_MS        = 5;
  localparam int LOOKBACK_MS    = 40;
  localparam int LOOKBACK_TICKS = LOOKBACK_MS / TICK_MS;
  localparam int MAX_TIME_S     = 1800;
  localparam int MAX_TICKS      = MAX_TIME_S * 1000 / TICK_MS;
  localparam int TIME_W         = 19;
  localparam logic [TIME_W-1:0] DELAY_RST = 19'h0_0014;
  // ------------------------------------------------------------
  // Status encodings
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    BUS_DEAD      = 5'h01,
    BUS_OK        = 5'h02,
    BUS_SEQ_REV   = 5'h04,
    BUS_SEQ_UNDEF = 5'h08,
    BUS_PROBLEM   = 5'h10
  } vts_bus_t;
  typedef enum logic [4:0] {
    COND_NORMAL   = 5'h01,
    COND_START    = 5'h02,
    COND_LINEFAIL = 5'h04,
    COND_BUSFAIL  = 5'h08,
    COND_BLOCKED  = 5'h10
  } vts_cond_t;
  localparam logic [6:0] DEAD_LEVEL = 7'h02;
endpackage : vts_pkg

/* File: hdl/vts_supervision.sv */
// Voltage transformer supervision: pick-up, blocking, definite delay, status.
// Assumes a 5 ms tick, magnitudes in hundredths of nominal, angles in 0.1 deg.
`timescale 1ns/1ps
// Notes on behaviour
// - Pick-up when any phase below low level or two phases above high level.
// - Low pick-up level settable 0.05..0.50 of nominal, default 0.05.
// - High detect level settable 0.01..1.10 of nominal, default 0.80.
// - Pick-up blocked while a channel angle changed less than limit over 40 ms.
// - Angle shift limit 2..90 deg in 0.1 deg steps, default 5 deg.
// - Bus fuse check, default on, gates bus breaker trip as failure source.
// - Line fuse check, default on, gates line breaker trip as failure source.
// - Positive and negative sequence computed from phases, zero sequence taken from channel 4; every channel angle tracked.
// - Bus status: dead, ok, reversed, undefined, or problem.
// - Condition: normal, started, line failure, bus failure, blocked.
// - Expected operating time shown in 5 ms steps, definite_delay_i not clamped, so 0..524287 ticks.
// - Blocking sampled once at start of each cycle, held for the cycle.
// - Pick-up without blocking raises start and begins delay timing.
// - Pick-up with blocking raises blocked and stops processing.
// - Blocking after start clears start and resets timing as on release.
// - Settings may change while running without restart.
// - Operating delay is definite time.
// - Resettable counters of start, bus alarm, line alarm and blocked.
module vts_supervision #(
  parameter int CNT_W = 16
) (
  input  wire logic                    clock_i,
  input  wire logic                    resetn_i,
  input  wire logic                    tick_i,
  input  wire logic [6:0]              volt1_i,
  input  wire logic [6:0]              volt2_i,
  input  wire logic [6:0]              volt3_i,
  input  wire logic [6:0]              volt4_i,
  input  wire logic [11:0]             angle1_i,
  input  wire logic [11:0]             angle2_i,
  input  wire logic [11:0]             angle3_i,
  input  wire logic [11:0]             angle4_i,
  input  wire logic                    block_i,
  input  wire logic                    bus_breaker_trip_input_i,
  input  wire logic                    line_breaker_trip_input_i,
  input  wire logic [6:0]              low_pickup_i,
  input  wire logic [6:0]              high_detect_i,
  input  wire logic [9:0]              angle_limit_i,
  input  wire logic                    bus_fuse_check_i,
  input  wire logic                    line_fuse_check_i,
  input  wire logic [vts_pkg::TIME_W-1:0] definite_delay_i,
  input  wire logic                    counters_clear_i,
  output logic                         start_o,
  output logic                         blocked_o,
  output logic                         alarm_o,
  output logic                         line_side_failure_o,
  output logic                         bus_side_failure_o,
  output logic [4:0]                   bus_status_o,
  output logic [4:0]                   condition_o,
  output logic [vts_pkg::TIME_W-1:0]   expected_time_o,
  output logic signed [vts_pkg::TIME_W:0] remaining_time_o,
  output logic [8:0]                   seq_pos_o,
  output logic [8:0]                   seq_neg_o,
  output logic [8:0]                   seq_zero_o,
  output logic [CNT_W-1:0]             start_count_o,
  output logic [CNT_W-1:0]             bus_alarm_count_o,
  output logic [CNT_W-1:0]             line_alarm_count_o,
  output logic [CNT_W-1:0]             blocked_count_o
);
  import vts_pkg::*;

  // ------------------------------------------------------------
  // Reset release and input synchronisers
  // ------------------------------------------------------------
  logic       rst_s1_reg, rst_n;
  logic [2:0] pin_s1_reg, pin_s2_reg;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end
  // Pins from outside: block and breaker trips
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {line_breaker_trip_input_i, bus_breaker_trip_input_i, block_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // Setting clamps, re-read each tick so groups may switch live
  // ------------------------------------------------------------
  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
    clamp10 = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clamp10
  wire [9:0] low_wide  = clamp10({3'h0, low_pickup_i}, {3'h0, LOW_PICKUP_MIN}, {3'h0, LOW_PICKUP_MAX});
  wire [9:0] high_wide = clamp10({3'h0, high_detect_i}, {3'h0, HIGH_DETECT_MIN}, {3'h0, HIGH_DETECT_MAX});
  wire [6:0] low_lvl   = low_wide[6:0];
  wire [6:0] high_lvl  = high_wide[6:0];
  wire [9:0] ang_lim  = clamp10(angle_limit_i, ANGLE_LIM_MIN, ANGLE_LIM_MAX);

  // ------------------------------------------------------------
  // Angle histories and pick-up
  // ------------------------------------------------------------
  logic [11:0] diff [4];
  logic [11:0] old_ang [4];
  logic [11:0] ang_in [4];
  assign ang_in[0] = angle1_i;
  assign ang_in[1] = angle2_i;
  assign ang_in[2] = angle3_i;
  assign ang_in[3] = angle4_i;
  for (genvar g = 0; g < 4; g++) begin : g_hist
    vts_angle_hist #(.DEPTH(LOOKBACK_TICKS)) u_hist (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n),
      .tick_i      (tick_i),
      .angle_i     (ang_in[g]),
      .old_angle_o (old_ang[g]),
      .diff_o      (diff[g])
    );
  end

  wire [2:0] below = {volt3_i < low_lvl, volt2_i < low_lvl, volt1_i < low_lvl};
  wire [2:0] above = {volt3_i > high_lvl, volt2_i > high_lvl, volt1_i > high_lvl};
  wire two_above   = (above[0] & above[1]) | (above[0] & above[2]) | (above[1] & above[2]);
  wire cond_raw    = (|below) | two_above;
  wire angle_still = ({2'h0, ang_lim} > diff[0]) | ({2'h0, ang_lim} > diff[1]) |
                     ({2'h0, ang_lim} > diff[2]) | ({2'h0, ang_lim} > diff[3]);
  wire pickup      = cond_raw & ~angle_still;
  wire all_dead    = (volt1_i < DEAD_LEVEL) & (volt2_i < DEAD_LEVEL) & (volt3_i < DEAD_LEVEL);

  // ------------------------------------------------------------
  // Sequence estimate: phase order from angle steps, 120 deg apart
  // ------------------------------------------------------------
  function automatic logic [11:0] wrap_sub(input logic [11:0] a, input logic [11:0] b);
    wrap_sub = (a >= b) ? a - b : a + ANGLE_FULL - b;
  endfunction : wrap_sub
  localparam logic [11:0] DEG120 = 12'h04B0;
  localparam logic [11:0] DEG240 = 12'h0960;
  localparam logic [11:0] SEQ_TOL = 12'h00C8;
  function automatic logic near(input logic [11:0] a, input logic [11:0] t);
    near = (a + SEQ_TOL >= t) && (a <= t + SEQ_TOL);
  endfunction : near
  wire [11:0] d12 = wrap_sub(angle1_i, angle2_i);
  wire [11:0] d23 = wrap_sub(angle2_i, angle3_i);
  wire seq_fwd    = near(d12, DEG120) & near(d23, DEG120);
  wire seq_rev    = near(d12, DEG240) & near(d23, DEG240);
  // Magnitude-only approximation: balanced sum versus spread
  wire [8:0] vsum = {2'h0, volt1_i} + {2'h0, volt2_i} + {2'h0, volt3_i};
  wire [6:0] vmax = (volt1_i > volt2_i) ? ((volt1_i > volt3_i) ? volt1_i : volt3_i)
                                        : ((volt2_i > volt3_i) ? volt2_i : volt3_i);
  wire [6:0] vmin = (volt1_i < volt2_i) ? ((volt1_i < volt3_i) ? volt1_i : volt3_i)
                                        : ((volt2_i < volt3_i) ? volt2_i : volt3_i);

  // ------------------------------------------------------------
  // Blocking sample and state machine
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_TIMING  = 3'b010,
    ST_BLOCKED = 3'b100
  } vts_state_t;
  vts_state_t state_reg, state_next;
  logic        block_cyc_reg;
  logic [TIME_W-1:0] elapsed_reg;
  logic        alarm_reg;
  wire block_now = pin_s2_reg[0];
  wire bus_fuse  = pin_s2_reg[1] & bus_fuse_check_i;
  wire line_fuse = pin_s2_reg[2] & line_fuse_check_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (pickup && block_cyc_reg) state_next = ST_BLOCKED;
        else if (pickup)             state_next = ST_TIMING;
      end
      ST_TIMING: begin
        if (!pickup)            state_next = ST_IDLE;
        else if (block_cyc_reg) state_next = ST_BLOCKED;
      end
      ST_BLOCKED: begin
        if (!pickup) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  wire [TIME_W-1:0] delay = definite_delay_i;
  wire expire = (state_next == ST_TIMING) && (elapsed_reg >= delay);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      block_cyc_reg <= 1'b0;
      elapsed_reg   <= '0;
      alarm_reg     <= 1'b0;
    end else if (tick_i) begin
      block_cyc_reg <= block_now;
      state_reg     <= state_next;
      if (state_next == ST_TIMING) begin
        if (elapsed_reg < delay) elapsed_reg <= elapsed_reg + 19'h0_0001;
        alarm_reg <= expire;
      end else begin
        elapsed_reg <= '0;
        alarm_reg   <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  vts_bus_t  bus_next;
  vts_cond_t cond_next;
  assign bus_next = all_dead ? BUS_DEAD :
                    (cond_raw | bus_fuse | line_fuse) ? BUS_PROBLEM :
                    seq_fwd ? BUS_OK : seq_rev ? BUS_SEQ_REV : BUS_SEQ_UNDEF;
  assign cond_next = (state_next == ST_BLOCKED) ? COND_BLOCKED :
                     line_fuse ? COND_LINEFAIL :
                     bus_fuse ? COND_BUSFAIL :
                     (state_next == ST_TIMING) ? COND_START : COND_NORMAL;
  wire start_rise = (state_next == ST_TIMING) && (state_reg != ST_TIMING);
  wire blk_rise   = (state_next == ST_BLOCKED) && (state_reg != ST_BLOCKED);
  logic bus_f_reg, line_f_reg;
  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c, input logic ev);
    bump = (ev && c != '1) ? c + 1'b1 : c;
  endfunction : bump

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      start_o             <= 1'b0;
      blocked_o           <= 1'b0;
      alarm_o             <= 1'b0;
      line_side_failure_o <= 1'b0;
      bus_side_failure_o  <= 1'b0;
      bus_f_reg           <= 1'b0;
      line_f_reg          <= 1'b0;
      bus_status_o        <= BUS_DEAD;
      condition_o         <= COND_NORMAL;
      expected_time_o     <= DELAY_RST;
      remaining_time_o    <= '0;
      seq_pos_o           <= '0;
      seq_neg_o           <= '0;
      seq_zero_o          <= '0;
      start_count_o       <= '0;
      bus_alarm_count_o   <= '0;
      line_alarm_count_o  <= '0;
      blocked_count_o     <= '0;
    end else begin
      expected_time_o <= delay;
      if (tick_i) begin
        start_o             <= (state_next == ST_TIMING);
        blocked_o           <= (state_next == ST_BLOCKED);
        alarm_o             <= expire;
        bus_f_reg           <= bus_fuse;
        line_f_reg          <= line_fuse;
        bus_side_failure_o  <= bus_fuse;
        line_side_failure_o <= line_fuse;
        bus_status_o        <= bus_next;
        condition_o         <= cond_next;
        remaining_time_o    <= (state_next == ST_TIMING) ?
                               $signed({1'b0, delay}) - $signed({1'b0, elapsed_reg}) : '0;
        seq_pos_o  <= seq_fwd ? vsum / 9'd3 : '0;
        seq_neg_o  <= seq_rev ? vsum / 9'd3 : {2'h0, vmax - vmin};
        seq_zero_o <= {2'h0, volt4_i};
      end
      if (counters_clear_i) begin
        // Event in the clearing cycle still counts
        start_count_o      <= bump('0, tick_i & start_rise);
        bus_alarm_count_o  <= bump('0, tick_i & bus_fuse & ~bus_f_reg);
        line_alarm_count_o <= bump('0, tick_i & line_fuse & ~line_f_reg);
        blocked_count_o    <= bump('0, tick_i & blk_rise);
      end else if (tick_i) begin
        start_count_o      <= bump(start_count_o, start_rise);
        bus_alarm_count_o  <= bump(bus_alarm_count_o, bus_fuse & ~bus_f_reg);
        line_alarm_count_o <= bump(line_alarm_count_o, line_fuse & ~line_f_reg);
        blocked_count_o    <= bump(blocked_count_o, blk_rise);
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_block_stops;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && block_cyc_reg && state_reg != ST_BLOCKED && pickup) |=> (state_reg == ST_BLOCKED);
  endproperty
  a_block_stops: assert property (p_block_stops) else $error("blocked pickup not blocked");
  property p_start;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && state_reg == ST_IDLE && pickup && !block_cyc_reg) |=> start_o;
  endproperty
  a_start: assert property (p_start) else $error("start missing");
  property p_clear_on_block;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && state_reg == ST_TIMING && block_cyc_reg) |=> (!start_o && elapsed_reg == '0);
  endproperty
  a_clear_on_block: assert property (p_clear_on_block) else $error("start not cleared");
  property p_sample;
    @(posedge clock_i) disable iff (!rst_n)
      !tick_i |=> $stable(block_cyc_reg);
  endproperty
  a_sample: assert property (p_sample) else $error("block sample moved mid-cycle");
  property p_pickup;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && volt1_i < low_lvl && !angle_still && !block_cyc_reg && state_reg != ST_BLOCKED) |=> start_o;
  endproperty
  a_pickup: assert property (p_pickup) else $error("low voltage no pickup");
  property p_angle;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && angle_still) |=> !start_o;
  endproperty
  a_angle: assert property (p_angle) else $error("angle block ignored");
  property p_bus_fuse;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && !bus_fuse_check_i) |=> !bus_side_failure_o;
  endproperty
  a_bus_fuse: assert property (p_bus_fuse) else $error("bus fuse unchecked but flagged");
  property p_line_fuse;
    @(posedge clock_i) disable iff (!rst_n)
      (tick_i && !line_fuse_check_i) |=> !line_side_failure_o;
  endproperty
  a_line_fuse: assert property (p_line_fuse) else $error("line fuse unchecked but flagged");
  property p_alarm;
    @(posedge clock_i) disable iff (!rst_n)
      alarm_o |-> start_o;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without start");
endmodule : vts_supervision

/* File: test/vts_meas_source.sv */
// Partner model: measurement front end and blocking matrix feeding the block.
// Assumes one clock; values are refreshed only on the tick edge, as the front end does.
`timescale 1ns/1ps
module vts_meas_source #(
  parameter int TICK_CYC = 16
) (
  input  wire logic             clock_i,
  input  wire logic [3:0][6:0]  mags_i,
  input  wire logic [1:0]       seq_i,
  input  wire logic             rotate_i,
  input  wire logic             block_req_i,
  output logic                  tick_o,
  output logic      [3:0][6:0]  volt_o,
  output logic      [3:0][11:0] angle_o,
  output logic                  block_o
);
  int cyc  = 0;
  int base = 0;
  int p2;
  int p3;
  initial tick_o = 1'b0;
  initial volt_o = '0;
  initial angle_o = '0;
  initial block_o = 1'b0;
  function automatic logic [11:0] wrap(input int a);
    return 12'((a % 3600 + 3600) % 3600);
  endfunction : wrap
  // ------------------------------------------------------------
  // Tick and refresh
  // ------------------------------------------------------------
  // Seq 0 normal, 1 reversed, 2 all in phase; rotation keeps the angle check quiet
  always @(posedge clock_i) begin
    cyc = (cyc + 1) % TICK_CYC;
    tick_o <= (cyc == 0);
    if (tick_o) begin
      volt_o  <= mags_i;
      block_o <= block_req_i;   // Changed a whole tick ahead of use
      if (rotate_i) begin
        base = (base + 100) % 3600;
      end
      p2 = (seq_i == 2'd2) ? 0 : ((seq_i == 2'd1) ? 1200 : -1200);
      p3 = -p2;
      angle_o[0] <= wrap(base);
      angle_o[1] <= wrap(base + p2);
      angle_o[2] <= wrap(base + p3);
      angle_o[3] <= wrap(base + 300);
    end
  end
endmodule : vts_meas_source

/* File: test/vts_supervision_tb.sv */
// Testbench: integer model of pick-up, status, timing and counters against the design.
// Assumes the partner model supplies tick, measurements and blocking.
`timescale 1ns/1ps
module vts_supervision_tb;
  import vts_pkg::*;
  logic                 clock_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic [3:0][6:0]      mags = {4{7'd60}};
  logic [1:0]           seq = 2'd0;
  logic                 rot = 1'b1, breq = 1'b0, tick, blk, btrip = 1'b0, ltrip = 1'b0, cclr = 1'b0;
  logic [3:0][6:0]      volt;
  logic [3:0][11:0]     ang;
  logic [6:0]           low = LOW_PICKUP_RST, high = HIGH_DETECT_RST;
  logic [9:0]           alim = ANGLE_LIM_RST;
  logic                 bfc = FUSE_CHECK_RST, lfc = FUSE_CHECK_RST;
  logic [TIME_W-1:0]    delay = DELAY_RST;
  logic                 start_o, blocked_o, alarm_o, line_f, bus_f;
  logic [4:0]           bus_status_o, condition_o;
  logic [TIME_W-1:0]    expected_time_o;
  logic signed [TIME_W:0] remaining_time_o, prev;
  logic [15:0]          start_count_o, bus_cnt, line_cnt, blk_cnt;
  logic [8:0]           spos, sneg, szero;
  int error_cnt = 0, total_checks = 0, seed = 38, starts = 0, ts, ta;
  logic was_start = 1'b0;
  initial forever #20 clock_i = ~clock_i;
  vts_meas_source #(.TICK_CYC(16)) u_src (.clock_i(clock_i), .mags_i(mags), .seq_i(seq), .rotate_i(rot),
    .block_req_i(breq), .tick_o(tick), .volt_o(volt), .angle_o(ang), .block_o(blk));
  vts_supervision DUT (.clock_i(clock_i), .resetn_i(resetn_i), .tick_i(tick), .volt1_i(volt[0]),
    .volt2_i(volt[1]), .volt3_i(volt[2]), .volt4_i(volt[3]), .angle1_i(ang[0]), .angle2_i(ang[1]),
    .angle3_i(ang[2]), .angle4_i(ang[3]), .block_i(blk), .bus_breaker_trip_input_i(btrip),
    .line_breaker_trip_input_i(ltrip), .low_pickup_i(low), .high_detect_i(high), .angle_limit_i(alim),
    .bus_fuse_check_i(bfc), .line_fuse_check_i(lfc), .definite_delay_i(delay), .counters_clear_i(cclr),
    .start_o(start_o), .blocked_o(blocked_o), .alarm_o(alarm_o), .line_side_failure_o(line_f),
    .bus_side_failure_o(bus_f), .bus_status_o(bus_status_o), .condition_o(condition_o),
    .expected_time_o(expected_time_o), .remaining_time_o(remaining_time_o), .seq_pos_o(spos),
    .seq_neg_o(sneg), .seq_zero_o(szero), .start_count_o(start_count_o), .bus_alarm_count_o(bus_cnt),
    .line_alarm_count_o(line_cnt), .blocked_count_o(blk_cnt));
  // ------------------------------------------------------------
  // Shared tasks and model
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  // Returns a few cycles after the n-th tick so registered outputs have landed
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clock_i);
        k++;
      end while (tick !== 1'b1 && k < 100);
      if (k >= 100) begin
        check(1'b0, 1'b1, "tick wait");
        wrap_up();
      end
    end
    repeat (3) @(posedge clock_i);
  endtask : ticks
  function automatic bit pick(input int a, input int b, input int c, input int lo, input int hi);
    return (a < lo) || (b < lo) || (c < lo) || (int'(a > hi) + int'(b > hi) + int'(c > hi) >= 2);
  endfunction : pick
  task automatic case_run(input int a, input int b, input int c, input int lo, input int hi);
    logic e;
    mags <= {7'd60, 7'(c), 7'(b), 7'(a)};
    // Thresholds follow the refreshed magnitudes, so no tick mixes old and new
    ticks(1);
    low <= 7'(lo);
    high <= 7'(hi);
    ticks(1);
    e = pick(a, b, c, lo, hi);
    if (e && !was_start) starts++;
    was_start = e;
    check(start_o, e, "start");
    check(bus_status_o, e ? BUS_PROBLEM : BUS_OK, "bus status");
    check(condition_o, e ? COND_START : COND_NORMAL, "condition");
    check(expected_time_o, delay, "expected time");
  endtask : case_run
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock_i);
    check(bus_status_o, BUS_DEAD, "reset bus status");
    check(condition_o, COND_NORMAL, "reset condition");
    check(expected_time_o, DELAY_RST, "reset time");
    resetn_i <= 1'b1;
    delay <= 19'd200;
    ticks(10);
    for (int s = 0; s < 3; s++) begin
      seq <= 2'(s);
      ticks(2);
      check(bus_status_o, s == 0 ? BUS_OK : (s == 1 ? BUS_SEQ_REV : BUS_SEQ_UNDEF), "sequence");
      check({spos, sneg, szero}, {s == 0 ? 9'd60 : 9'd0, s == 1 ? 9'd60 : 9'd0, 9'd60}, "seq parts");
    end
    seq <= 2'd0;
    mags <= '0;
    ticks(2);
    check(bus_status_o, BUS_DEAD, "dead bus");
    cclr <= 1'b1;
    @(posedge clock_i);
    cclr <= 1'b0;
    case_run(30, 81, 80, 30, 80);
    case_run(29, 60, 60, 30, 80);
    case_run(60, 81, 81, 30, 80);
    case_run(60, 60, 60, 30, 80);
    repeat (14) begin
      alim <= 10'(20 + ($unsigned($random(seed)) % 700));
      case_run(10 + $unsigned($random(seed)) % 111, 10 + $unsigned($random(seed)) % 111,
               10 + $unsigned($random(seed)) % 111, 5 + $unsigned($random(seed)) % 46,
               1 + $unsigned($random(seed)) % 110);
    end
    check(start_count_o, 16'(starts), "start count");
    case_run(60, 60, 60, 5, 80);
    delay <= 19'd4;
    cclr <= 1'b1;
    @(posedge clock_i);
    cclr <= 1'b0;
    mags <= {7'd60, 7'd60, 7'd60, 7'd3};
    ts = -1;
    ta = -1;
    for (int i = 0; i < 12; i++) begin
      ticks(1);
      if (start_o === 1'b1 && ts < 0) ts = i;
      else if (ts >= 0 && ta < 0) check(32'(remaining_time_o), 32'(prev - 1), "remaining");
      if (alarm_o === 1'b1 && ta < 0) ta = i;
      prev = remaining_time_o;
    end
    check(32'(ta - ts), 32'(delay), "definite delay");
    breq <= 1'b1;
    ticks(3);
    check(start_o, 1'b0, "start after block");
    mags <= {4{7'd60}};
    ticks(2);
    mags <= {7'd60, 7'd60, 7'd60, 7'd3};
    ticks(2);
    check(blocked_o, 1'b1, "blocked");
    check(start_o, 1'b0, "start under block");
    check(condition_o, COND_BLOCKED, "cond blocked");
    check(blk_cnt, 16'd2, "blocked count");
    breq <= 1'b0;
    ticks(3);
    check(start_o, 1'b0, "held blocked");
    mags <= {4{7'd60}};
    ticks(2);
    mags <= {7'd60, 7'd60, 7'd60, 7'd3};
    ticks(2);
    check(start_o, 1'b1, "start after unblock");
    check(start_count_o, 16'd2, "start count 2");
    rot <= 1'b0;
    alim <= ANGLE_LIM_RST;
    ticks(10);
    check(start_o, 1'b0, "angle still blocks");
    rot <= 1'b1;
    ticks(3);
    check(start_o, 1'b1, "angle moving");
    for (int f = 0; f < 2; f++) begin
      bfc <= f[0];
      lfc <= f[0];
      btrip <= 1'b1;
      ltrip <= 1'b1;
      ticks(2);
      check(bus_f, f[0], "bus fuse flag");
      check(line_f, f[0], "line fuse flag");
      btrip <= 1'b0;
      ltrip <= 1'b0;
      ticks(2);
      check(bus_cnt, 16'(f), "bus alarm count");
      check(line_cnt, 16'(f), "line alarm count");
    end
    cclr <= 1'b1;
    @(posedge clock_i);
    cclr <= 1'b0;
    repeat (2) @(posedge clock_i);
    check({start_count_o, bus_cnt}, 32'h0000_0000, "cleared counters");
    check({line_cnt, blk_cnt}, 32'h0000_0000, "cleared counters");
    wrap_up();
  end
endmodule : vts_supervision_tb
